// File: rtl/lcd_map.svh
// Register offsets, field positions, opcodes and cycle counts
`ifndef LCD_MAP_SVH
`define LCD_MAP_SVH
`define LCD_CTRL_OFS 12'h000
`define LCD_INSTR_OFS 12'h004
`define LCD_ACC_OFS 12'h008
`define LCD_B_OFS 12'h00C
`define LCD_PSW_OFS 12'h010
`define LCD_PC_OFS 12'h014
`define LCD_STAT_OFS 12'h018
`define LCD_RAM_SEL 2'h1
`define LCD_CTRL_GO 0
`define LCD_STAT_BUSY 0
`define LCD_STAT_ILL 1
`define LCD_PSW_C 7
`define LCD_PSW_AC 6
`define LCD_PSW_EXC 2
`define LCD_PSW_P 0
`define LCD_ACC_RST 8'h00
`define LCD_B_RST 8'h00
`define LCD_PC_RST 16'h0000
`define LCD_BIT_BASE 8'h20
`define LCD_MASK_REG 8'hF8
`define LCD_MASK_IND 8'hFE
`define LCD_OP_AND_A_IMM 8'h54
`define LCD_OP_AND_A_IND 8'h56
`define LCD_OP_AND_A_REG 8'h58
`define LCD_OP_AND_A_DIR 8'h55
`define LCD_OP_AND_C_BIT 8'h82
`define LCD_OP_AND_C_NBIT 8'hB0
`define LCD_OP_AND_DIR_IMM 8'h53
`define LCD_OP_AND_DIR_A 8'h52
`define LCD_OP_CJ_IND 8'hB6
`define LCD_OP_CJ_A_IMM 8'hB4
`define LCD_OP_CJ_A_DIR 8'hB5
`define LCD_OP_CJ_REG 8'hB8
`define LCD_OP_ZERO_A 8'hE4
`define LCD_OP_INV_A 8'hF4
`define LCD_OP_ADJ_A 8'hD4
`define LCD_OP_DIV 8'h84
`define LCD_CYC_1 3'h1
`define LCD_CYC_2 3'h2
`define LCD_CYC_4 3'h4
`define LCD_CJ_LEN 2'h3
`endif

// File: rtl/lcd_pkg.sv
// Types shared by the execution unit
package lcd_pkg;
    typedef enum logic [4:0] {
        OP_NONE = 5'b00000, OP_AND_A_IMM = 5'b00001, OP_AND_A_IND = 5'b00010,
        OP_AND_A_REG = 5'b00011, OP_AND_A_DIR = 5'b00100, OP_AND_C_BIT = 5'b00101,
        OP_AND_C_NBIT = 5'b00110, OP_AND_DIR_IMM = 5'b00111, OP_AND_DIR_A = 5'b01000,
        OP_CJ_IND = 5'b01001, OP_CJ_A_IMM = 5'b01010, OP_CJ_A_DIR = 5'b01011,
        OP_CJ_REG = 5'b01100, OP_ZERO_A = 5'b01101, OP_INV_A = 5'b01110,
        OP_ADJ_A = 5'b01111, OP_DIV = 5'b10000
    } lcd_op_t;
    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} lcd_state_t;
endpackage

// File: rtl/lcd_ram_if.sv
// Two read ports and one write port of the on-chip data memory
`timescale 1ns/1ps
interface lcd_ram_if;
    logic [7:0] a_addr;
    logic [7:0] a_data;
    logic [7:0] b_addr;
    logic [7:0] b_data;
    logic we;
    logic [7:0] w_addr;
    logic [7:0] w_data;
    modport user (output a_addr, b_addr, we, w_addr, w_data, input a_data, b_data);
    modport mem (input a_addr, b_addr, we, w_addr, w_data, output a_data, b_data);
endinterface

// File: rtl/lcd_ram.sv
// On-chip data memory: 256 bytes, working registers at the bottom
`timescale 1ns/1ps
module lcd_ram (
    // Clock
    input wire logic clk,
    // Memory ports
    lcd_ram_if.mem bus
);
    logic [7:0] mem_q [0:255];

    // Contents are not reset; software loads what it needs
    always_ff @(posedge clk) begin
        if (bus.we) begin
            mem_q[bus.w_addr] <= bus.w_data;
        end
    end

    assign bus.a_data = mem_q[bus.a_addr];
    assign bus.b_data = mem_q[bus.b_addr];
endmodule // lcd_ram

// File: rtl/lcd_alu.sv
// Arithmetic for AND, compare, clear, complement, decimal adjust and divide
`timescale 1ns/1ps
module lcd_alu (
    // Operation and state
    input wire lcd_pkg::lcd_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] b,
    input wire logic c,
    input wire logic ac,
    input wire logic exc,
    // Operands
    input wire logic [7:0] x,
    input wire logic [7:0] y,
    input wire logic bitv,
    // Results
    output logic [7:0] acc_n,
    output logic [7:0] b_n,
    output logic c_n,
    output logic exc_n,
    output logic [7:0] mem_n,
    output logic neq
);
    import lcd_pkg::*;

    logic [8:0] lo;
    logic [8:0] hi;

    assign mem_n = x & y;
    assign neq = x != y;

    always_comb begin
        acc_n = acc;
        b_n = b;
        c_n = c;
        exc_n = exc;
        lo = {1'b0, acc};
        hi = lo;
        case (op)
            OP_AND_A_IMM, OP_AND_A_IND, OP_AND_A_REG, OP_AND_A_DIR: acc_n = acc & x;
            OP_AND_C_BIT: c_n = c & bitv;
            OP_AND_C_NBIT: c_n = c & ~bitv;
            OP_CJ_IND, OP_CJ_A_IMM, OP_CJ_A_DIR, OP_CJ_REG: c_n = x < y;
            OP_ZERO_A: acc_n = 8'h00;
            OP_INV_A: acc_n = ~acc;
            OP_ADJ_A: begin
                if (acc[3:0] > 4'h9 || ac) begin
                    lo = lo + 9'h006;
                end
                hi = lo;
                if (lo[7:4] > 4'h9 || c || lo[8]) begin
                    hi = {1'b0, lo[7:0]} + 9'h060;
                end
                acc_n = hi[7:0];
                // Carry is only ever set here, never cleared
                c_n = c | lo[8] | hi[8];
            end
            OP_DIV: begin
                c_n = 1'b0;
                exc_n = b == 8'h00;
                if (b != 8'h00) begin
                    acc_n = acc / b;
                    b_n = acc % b;
                end
            end
            default: ;
        endcase
    end
endmodule // lcd_alu

// File: rtl/lcd_core.sv
// Execution unit with APB register access and on-chip data memory
`timescale 1ns/1ps
`include "lcd_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - AND A with working register or indirect byte; parity only; one cycle.
// - Two-byte AND of direct byte into A, parity only.
// - AND carry with addressed bit, other flags untouched, two cycles.
// - AND carry with inverted bit; the source bit stays unchanged.
// - Three-byte AND of immediate into direct byte, two cycles, no flags.
// - AND A into direct byte, one cycle, no flags.
// - Compare-branch adds three to PC, then offset only if operands differ.
// - Compare-branch carry is unsigned first-less-than-second, else cleared.
// - Three compare-branch forms plus indirect, each two cycles, three bytes.
// - Clear or complement A in one cycle, parity updated.
// - Decimal adjust A in one cycle, parity and carry updated.
// - Unsigned divide A by B in four cycles, parity, overflow, carry.
// - Opcode register field selects one of eight working registers.
// - Branch offset is signed and added to the advanced PC.
module lcd_core (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    import lcd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    lcd_state_t state_q;
    lcd_op_t op_q;
    lcd_op_t decoded;
    logic [2:0] cnt_q;
    logic [23:0] instr_q;
    logic [7:0] acc_q, acc_d, b_q;
    logic c_q, ac_q, exc_q, p_q, illegal_q;
    logic [15:0] pc_q, pc_d, rel_ext;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q, rdata;
    logic err, run, commit, wr_en, go;
    logic wr_ctrl, wr_instr, wr_acc, wr_b, wr_psw, wr_pc, wr_stat, wr_ram;
    logic [7:0] opc, op1, op2, x, y, psw_rd;
    logic [7:0] alu_acc, alu_b, alu_mem;
    logic alu_c, alu_exc, neq, bitv, ind, bit_op;

    lcd_ram_if ram ();

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers
    function automatic lcd_op_t op_decode(input logic [7:0] o);
        lcd_op_t r;
        r = OP_NONE;
        if ((o & `LCD_MASK_REG) == `LCD_OP_AND_A_REG) begin
            r = OP_AND_A_REG;
        end else if ((o & `LCD_MASK_IND) == `LCD_OP_AND_A_IND) begin
            r = OP_AND_A_IND;
        end else if (o == `LCD_OP_AND_A_IMM) begin
            r = OP_AND_A_IMM;
        end else if (o == `LCD_OP_AND_A_DIR) begin
            r = OP_AND_A_DIR;
        end else if (o == `LCD_OP_AND_C_BIT) begin
            r = OP_AND_C_BIT;
        end else if (o == `LCD_OP_AND_C_NBIT) begin
            r = OP_AND_C_NBIT;
        end else if (o == `LCD_OP_AND_DIR_IMM) begin
            r = OP_AND_DIR_IMM;
        end else if (o == `LCD_OP_AND_DIR_A) begin
            r = OP_AND_DIR_A;
        end else if ((o & `LCD_MASK_IND) == `LCD_OP_CJ_IND) begin
            r = OP_CJ_IND;
        end else if (o == `LCD_OP_CJ_A_IMM) begin
            r = OP_CJ_A_IMM;
        end else if (o == `LCD_OP_CJ_A_DIR) begin
            r = OP_CJ_A_DIR;
        end else if ((o & `LCD_MASK_REG) == `LCD_OP_CJ_REG) begin
            r = OP_CJ_REG;
        end else if (o == `LCD_OP_ZERO_A) begin
            r = OP_ZERO_A;
        end else if (o == `LCD_OP_INV_A) begin
            r = OP_INV_A;
        end else if (o == `LCD_OP_ADJ_A) begin
            r = OP_ADJ_A;
        end else if (o == `LCD_OP_DIV) begin
            r = OP_DIV;
        end
        return r;
    endfunction

    function automatic logic is_cj(input lcd_op_t o);
        return o == OP_CJ_IND || o == OP_CJ_A_IMM || o == OP_CJ_A_DIR || o == OP_CJ_REG;
    endfunction

    function automatic logic [2:0] op_cycles(input lcd_op_t o);
        logic [2:0] n;
        n = `LCD_CYC_1;
        if (o == OP_DIV) begin
            n = `LCD_CYC_4;
        end else if (is_cj(o) || o == OP_AND_DIR_IMM) begin
            n = `LCD_CYC_2;
        end else if (o == OP_AND_C_BIT || o == OP_AND_C_NBIT) begin
            n = `LCD_CYC_2;
        end
        return n;
    endfunction

    function automatic logic [1:0] op_len(input lcd_op_t o);
        logic [1:0] n;
        n = 2'h1;
        if (is_cj(o) || o == OP_AND_DIR_IMM) begin
            n = `LCD_CJ_LEN;
        end else if (o == OP_AND_A_IMM || o == OP_AND_A_DIR || o == OP_AND_DIR_A) begin
            n = 2'h2;
        end else if (o == OP_AND_C_BIT || o == OP_AND_C_NBIT) begin
            n = 2'h2;
        end
        return n;
    endfunction

    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        return a[7] ? {a[7:3], 3'h0} : `LCD_BIT_BASE + {4'h0, a[6:3]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Operand selection
    assign opc = instr_q[7:0];
    assign op1 = instr_q[15:8];
    assign op2 = instr_q[23:16];
    assign run = state_q == ST_RUN;
    assign commit = run && cnt_q == 3'h1;
    assign bitv = ram.a_data[op1[2:0]];
    assign rel_ext = {{8{op2[7]}}, op2};

    always_comb begin
        ind = op_q == OP_AND_A_IND || op_q == OP_CJ_IND;
        bit_op = op_q == OP_AND_C_BIT || op_q == OP_AND_C_NBIT;
        ram.b_addr = ind ? {7'h00, opc[0]} : {5'h00, opc[2:0]};
        if (!run) begin
            ram.a_addr = PADDR[9:2];
        end else if (ind) begin
            ram.a_addr = ram.b_data;
        end else if (bit_op) begin
            ram.a_addr = bit_byte(op1);
        end else begin
            ram.a_addr = op1;
        end
        x = ram.a_data;
        y = op2;
        case (op_q)
            OP_AND_A_IMM: x = op1;
            OP_AND_A_REG: x = ram.b_data;
            OP_AND_DIR_A: y = acc_q;
            OP_CJ_IND: y = op1;
            OP_CJ_A_IMM: begin
                x = acc_q;
                y = op1;
            end
            OP_CJ_A_DIR: begin
                x = acc_q;
                y = ram.a_data;
            end
            OP_CJ_REG: begin
                x = ram.b_data;
                y = op1;
            end
            default: ;
        endcase
    end

    lcd_alu u_alu (
        .op(op_q), .acc(acc_q), .b(b_q), .c(c_q), .ac(ac_q), .exc(exc_q),
        .x(x), .y(y), .bitv(bitv),
        .acc_n(alu_acc), .b_n(alu_b), .c_n(alu_c), .exc_n(alu_exc),
        .mem_n(alu_mem), .neq(neq)
    );

    lcd_ram u_ram (.clk(CLOCK), .bus(ram.mem));

    // Direct-byte results go to memory; the source bit of a bit AND is never written
    assign ram.we = (commit && (op_q == OP_AND_DIR_IMM || op_q == OP_AND_DIR_A)) || wr_ram;
    assign ram.w_addr = commit ? op1 : PADDR[9:2];
    assign ram.w_data = commit ? alu_mem : PWDATA[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode
    always_comb begin
        rdata = 32'h0000_0000;
        err = 1'b0;
        psw_rd = 8'h00;
        psw_rd[`LCD_PSW_C] = c_q;
        psw_rd[`LCD_PSW_AC] = ac_q;
        psw_rd[`LCD_PSW_EXC] = exc_q;
        psw_rd[`LCD_PSW_P] = p_q;
        // Core state is frozen while an instruction runs
        if (PADDR[1:0] != 2'h0) begin
            err = 1'b1;
        end else if (PADDR == `LCD_CTRL_OFS) begin
            err = run && PWRITE;
        end else if (PADDR == `LCD_INSTR_OFS) begin
            rdata = {8'h00, instr_q};
            err = run && PWRITE;
        end else if (PADDR == `LCD_ACC_OFS) begin
            rdata = {24'h00_0000, acc_q};
            err = run && PWRITE;
        end else if (PADDR == `LCD_B_OFS) begin
            rdata = {24'h00_0000, b_q};
            err = run && PWRITE;
        end else if (PADDR == `LCD_PSW_OFS) begin
            rdata = {24'h00_0000, psw_rd};
            err = run && PWRITE;
        end else if (PADDR == `LCD_PC_OFS) begin
            rdata = {16'h0000, pc_q};
            err = run && PWRITE;
        end else if (PADDR == `LCD_STAT_OFS) begin
            rdata[`LCD_STAT_BUSY] = run;
            rdata[`LCD_STAT_ILL] = illegal_q;
        end else if (PADDR[11:10] == `LCD_RAM_SEL) begin
            rdata = {24'h00_0000, ram.a_data};
            err = run;
        end else begin
            err = 1'b1;
        end
    end

    assign wr_en = PSEL && PENABLE && pready_q && PWRITE && !pslverr_q;
    assign wr_ctrl = wr_en && PADDR == `LCD_CTRL_OFS;
    assign wr_instr = wr_en && PADDR == `LCD_INSTR_OFS;
    assign wr_acc = wr_en && PADDR == `LCD_ACC_OFS;
    assign wr_b = wr_en && PADDR == `LCD_B_OFS;
    assign wr_psw = wr_en && PADDR == `LCD_PSW_OFS;
    assign wr_pc = wr_en && PADDR == `LCD_PC_OFS;
    assign wr_stat = wr_en && PADDR == `LCD_STAT_OFS;
    assign wr_ram = wr_en && PADDR[11:10] == `LCD_RAM_SEL;

    // One wait state: answer registered in the first access cycle
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= PSEL && PENABLE && !pready_q;
            pslverr_q <= PSEL && PENABLE && !pready_q && err;
            if (PSEL && PENABLE && !pready_q) begin
                prdata_q <= rdata;
            end
        end
    end

    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PRDATA = prdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer
    assign decoded = op_decode(opc);
    assign go = wr_ctrl && PWDATA[`LCD_CTRL_GO];

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_q <= ST_IDLE;
            op_q <= OP_NONE;
            cnt_q <= 3'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (go && decoded != OP_NONE) begin
                        state_q <= ST_RUN;
                        op_q <= decoded;
                        cnt_q <= op_cycles(decoded);
                    end
                end
                ST_RUN: begin
                    cnt_q <= cnt_q - 3'h1;
                    if (cnt_q == 3'h1) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Unknown opcode: flag set wins over a same-cycle clear
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            illegal_q <= 1'b0;
        end else begin
            illegal_q <= (go && decoded == OP_NONE) ||
                (illegal_q && !(wr_stat && PWDATA[`LCD_STAT_ILL]));
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            instr_q <= 24'h00_0000;
        end else if (wr_instr) begin
            instr_q <= PWDATA[23:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Architectural state
    assign acc_d = wr_acc ? PWDATA[7:0] : (commit ? alu_acc : acc_q);

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            acc_q <= `LCD_ACC_RST;
            p_q <= ^`LCD_ACC_RST;
        end else begin
            acc_q <= acc_d;
            p_q <= ^acc_d;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            b_q <= `LCD_B_RST;
        end else if (wr_b) begin
            b_q <= PWDATA[7:0];
        end else if (commit) begin
            b_q <= alu_b;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            c_q <= 1'b0;
            ac_q <= 1'b0;
            exc_q <= 1'b0;
        end else if (wr_psw) begin
            c_q <= PWDATA[`LCD_PSW_C];
            ac_q <= PWDATA[`LCD_PSW_AC];
            exc_q <= PWDATA[`LCD_PSW_EXC];
        end else if (commit) begin
            c_q <= alu_c;
            exc_q <= alu_exc;
        end
    end

    assign pc_d = pc_q + {14'h0000, op_len(op_q)} + ((is_cj(op_q) && neq) ? rel_ext : 16'h0000);

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pc_q <= `LCD_PC_RST;
        end else if (wr_pc) begin
            pc_q <= PWDATA[15:0];
        end else if (commit) begin
            pc_q <= pc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    a_and_reg_flags: assert property (
        commit && op_q == OP_AND_A_REG |=> acc_q == ($past(acc_q) & $past(x))
        && c_q == $past(c_q) && exc_q == $past(exc_q)) else $error("AND register result wrong");
    a_and_dir_acc: assert property (
        commit && op_q == OP_AND_A_DIR |=> acc_q == ($past(acc_q) & $past(x)))
        else $error("AND direct result wrong");
    a_andc_timing: assert property (
        $rose(run) && op_q == OP_AND_C_BIT |-> run[*2] ##1 !run && exc_q == $past(exc_q, 3))
        else $error("Bit AND length or flags wrong");
    a_andnc_value: assert property (
        commit && op_q == OP_AND_C_NBIT |-> !ram.we ##1 c_q == ($past(c_q) & ~$past(bitv)))
        else $error("Inverted bit AND wrong");
    a_dir_imm_store: assert property (
        commit && op_q == OP_AND_DIR_IMM |-> ram.we && ram.w_data == (ram.a_data & op2)
        ##1 c_q == $past(c_q)) else $error("Immediate AND store wrong");
    a_dir_acc_store: assert property (
        $rose(run) && op_q == OP_AND_DIR_A |-> commit && ram.w_data == (ram.a_data & acc_q))
        else $error("Accumulator AND store wrong");
    a_cj_pc_step: assert property (
        commit && is_cj(op_q) && !neq |=> pc_q == $past(pc_q) + 16'h0003)
        else $error("Compare without branch did not step by three");
    a_cj_pc_rel: assert property (
        commit && is_cj(op_q) && neq |=> pc_q == $past(pc_q) + 16'h0003 + $past(rel_ext))
        else $error("Branch target wrong");
    a_cj_carry: assert property (
        commit && is_cj(op_q) |=> c_q == ($past(x) < $past(y)))
        else $error("Compare carry wrong");
    a_cj_timing: assert property (
        $rose(run) && is_cj(op_q) |-> run[*2] ##1 !run) else $error("Compare length wrong");
    a_zero_acc: assert property (
        commit && op_q == OP_ZERO_A |=> acc_q == 8'h00 && !p_q) else $error("Clear failed");
    a_adj_carry: assert property (
        commit && op_q == OP_ADJ_A && c_q |=> c_q) else $error("Adjust cleared carry");
    a_div_timing: assert property (
        $rose(run) && op_q == OP_DIV |-> run[*4] ##1 !run) else $error("Divide length wrong");
    a_div_zero: assert property (
        commit && op_q == OP_DIV && b_q == 8'h00 |=> exc_q && !c_q)
        else $error("Divide by zero flags wrong");
    a_reg_select: assert property (
        run && op_q == OP_CJ_REG |-> ram.b_addr == {5'h00, opc[2:0]})
        else $error("Working register select wrong");
    a_parity_track: assert property (
        p_q == ^acc_q) else $error("Parity does not follow accumulator");

    c_cj_taken: cover property (commit && is_cj(op_q) && neq);
    c_div_zero: cover property (commit && op_q == OP_DIV && b_q == 8'h00);
    c_adj_carry: cover property (commit && op_q == OP_ADJ_A && alu_c && !c_q);
    c_andnc: cover property (commit && op_q == OP_AND_C_NBIT && bitv);
endmodule // lcd_core

// File: sim/logic_compare_divide_ops_tb.sv
// Self-checking bench for the execution unit through its APB registers
`timescale 1ns/1ps
`include "lcd_map.svh"
module logic_compare_divide_ops_tb;
    logic CLOCK = 1'b0;
    logic RESET = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    int fail_count = 0;
    int checks = 0;
    lcd_core u_dut (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR));
    always #50 CLOCK = ~CLOCK;
    ////////////////////////////////////////////////////////////////////////////
    task test_done();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until PREADY is sampled high; answer taken at that edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1) begin
            fail_count++;
            test_done();
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        cmp(r, exp);
    endtask
    // Busy is polled, never assumed to last a fixed time
    task run(input logic [23:0] ins);
        logic [31:0] r;
        logic e;
        int n;
        wr(`LCD_INSTR_OFS, {8'h00, ins});
        wr(`LCD_CTRL_OFS, 32'h0000_0001);
        n = 0;
        do begin
            apb(1'b0, `LCD_STAT_OFS, 32'h0000_0000, r, e);
            n++;
        end while (r[0] !== 1'b0 && n < 20);
        if (r[0] !== 1'b0) begin
            fail_count++;
            test_done();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_and_a();
        wr(`LCD_ACC_OFS, 32'h0000_00F3);
        wr(12'h40C, 32'h0000_0035);
        run(24'h00_005B);
        rd(`LCD_ACC_OFS, 32'h0000_0031);
        rd(`LCD_PSW_OFS, 32'h0000_0001);
        wr(12'h404, 32'h0000_0030);
        wr(12'h4C0, 32'h0000_000F);
        run(24'h00_0057);
        rd(`LCD_ACC_OFS, 32'h0000_0001);
        wr(12'h500, 32'h0000_00FF);
        wr(`LCD_ACC_OFS, 32'h0000_003C);
        run(24'h00_4055);
        rd(`LCD_ACC_OFS, 32'h0000_003C);
        rd(`LCD_PC_OFS, 32'h0000_0004);
    endtask
    task t_and_mem();
        wr(12'h504, 32'h0000_00F0);
        run(24'h00_4152);
        rd(12'h504, 32'h0000_0030);
        run(24'h96_4153);
        rd(12'h504, 32'h0000_0010);
        rd(`LCD_PSW_OFS, 32'h0000_0000);
    endtask
    task t_clr_cpl();
        wr(`LCD_ACC_OFS, 32'h0000_000E);
        run(24'h00_00F4);
        rd(`LCD_ACC_OFS, 32'h0000_00F1);
        rd(`LCD_PSW_OFS, 32'h0000_0001);
        run(24'h00_3C54);
        rd(`LCD_ACC_OFS, 32'h0000_0030);
        rd(`LCD_PSW_OFS, 32'h0000_0000);
        run(24'h00_00E4);
        rd(`LCD_ACC_OFS, 32'h0000_0000);
        rd(`LCD_PSW_OFS, 32'h0000_0000);
    endtask
    task t_compare();
        wr(`LCD_PC_OFS, 32'h0000_0100);
        wr(`LCD_ACC_OFS, 32'h0000_0010);
        run(24'hFE_20B4);
        rd(`LCD_PC_OFS, 32'h0000_0101);
        rd(`LCD_PSW_OFS, 32'h0000_0081);
        wr(12'h408, 32'h0000_0050);
        run(24'h05_20BA);
        rd(`LCD_PC_OFS, 32'h0000_0109);
        rd(`LCD_PSW_OFS, 32'h0000_0001);
        wr(12'h540, 32'h0000_0010);
        run(24'h7F_50B5);
        rd(`LCD_PC_OFS, 32'h0000_010C);
        rd(`LCD_PSW_OFS, 32'h0000_0001);
        run(24'h03_20B7);
        rd(`LCD_PC_OFS, 32'h0000_0112);
        rd(`LCD_PSW_OFS, 32'h0000_0081);
    endtask
    task t_adjust_bit();
        wr(`LCD_ACC_OFS, 32'h0000_009A);
        run(24'h00_00D4);
        rd(`LCD_ACC_OFS, 32'h0000_0000);
        rd(`LCD_PSW_OFS, 32'h0000_0080);
        run(24'h00_00D4);
        rd(`LCD_ACC_OFS, 32'h0000_0060);
        rd(`LCD_PSW_OFS, 32'h0000_0080);
        wr(12'h480, 32'h0000_00FE);
        run(24'h00_00B0);
        rd(`LCD_PSW_OFS, 32'h0000_0080);
        rd(12'h480, 32'h0000_00FE);
        run(24'h00_0082);
        rd(`LCD_PSW_OFS, 32'h0000_0000);
    endtask
    task t_divide();
        wr(`LCD_ACC_OFS, 32'h0000_0064);
        wr(`LCD_B_OFS, 32'h0000_0007);
        run(24'h00_0084);
        rd(`LCD_ACC_OFS, 32'h0000_000E);
        rd(`LCD_B_OFS, 32'h0000_0002);
        rd(`LCD_PSW_OFS, 32'h0000_0001);
        wr(`LCD_B_OFS, 32'h0000_0000);
        run(24'h00_0084);
        rd(`LCD_PSW_OFS, 32'h0000_0005);
    endtask
    task t_refused();
        logic [31:0] r;
        logic e;
        apb(1'b0, 12'h3F0, 32'h0000_0000, r, e);
        cmp({31'h0, e}, 32'h0000_0001);
        apb(1'b1, 12'h006, 32'h0000_0055, r, e);
        cmp({31'h0, e}, 32'h0000_0001);
        wr(`LCD_INSTR_OFS, 32'h0000_00A5);
        wr(`LCD_CTRL_OFS, 32'h0000_0001);
        rd(`LCD_STAT_OFS, 32'h0000_0002);
        wr(`LCD_STAT_OFS, 32'h0000_0002);
        rd(`LCD_STAT_OFS, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge CLOCK);
        RESET <= 1'b0;
        rd(`LCD_ACC_OFS, 32'h0000_0000);
        rd(`LCD_PC_OFS, 32'h0000_0000);
        t_and_a();
        t_and_mem();
        t_clr_cpl();
        t_compare();
        t_adjust_bit();
        t_divide();
        t_refused();
        test_done();
    end
endmodule // logic_compare_divide_ops_tb
